// ===== fsr_regmap.sv
// Register bank of the fan sensor: decode, aliases, gated fan registers and read-back.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_regs.svh"
module fsr_regmap
  import fsr_pkg::*;
#(
  parameter fsr_byte_t MAKER_CODE = 8'h5a,
  parameter fsr_byte_t REV_CODE   = 8'h3c
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      reg_wr,
  input  wire logic      reg_rd,
  input  wire fsr_byte_t reg_addr,
  input  wire fsr_byte_t reg_wdata,
  output var  fsr_byte_t reg_rdata,
  input  wire fsr_byte_t local_temp_in,
  input  wire fsr_byte_t remote_signed_hi_in,
  input  wire fsr_byte_t remote_signed_lo_in,
  input  wire fsr_byte_t remote_unsigned_hi_in,
  input  wire fsr_byte_t remote_unsigned_lo_in,
  input  wire fsr_byte_t alert_flags_in,
  input  wire logic      not_ready_flag,
  input  wire fsr_byte_t fan_count_lo_in,
  input  wire fsr_byte_t fan_count_hi_in,
  input  wire fsr_byte_t fan_duty_in,
  input  wire fsr_idx_t  table_rd_idx,
  output var  fsr_byte_t table_rd_data,
  output var  logic      single_conversion_pulse,
  output var  logic      fan_program_enable,
  output var  fsr_byte_t pwm_speed_config,
  output var  fsr_byte_t fan_startup_config,
  output var  fsr_byte_t pwm_frequency_select,
  output var  fsr_byte_t enhanced_settings,
  output var  fsr_byte_t table_temp_offset,
  output var  fsr_byte_t table_hysteresis,
  output var  fsr_byte_t main_configuration,
  output var  fsr_byte_t conversion_rate,
  output var  fsr_byte_t local_high_limit,
  output var  fsr_byte_t remote_high_limit_upper,
  output var  fsr_byte_t remote_low_limit_upper,
  output var  fsr_byte_t remote_critical_limit,
  output var  fsr_byte_t remote_critical_hysteresis,
  output var  fsr_byte_t alert_masking,
  output var  fsr_byte_t pwm_manual_duty,
  output var  logic      high_res_active,
  output var  logic      smoothing_active
);
  localparam int NRW = 21;
  localparam int I_CFG = 0, I_CONV = 1, I_LHI = 2, I_RHI = 3, I_RLO = 4, I_AMSK = 9;
  localparam int I_CRIT = 10, I_CHYS = 11, I_ENH = 12, I_PCFG = 15, I_SPIN = 16;
  localparam int I_FREQ = 17, I_TOFF = 18, I_THYS = 19;

  // Plain read-write registers: offset, reset value, writable bits, gated bits.
  function automatic fsr_byte_t rw_addr(input int i);
    case (i)
      0: rw_addr = `FSR_A_CFG;
      1: rw_addr = `FSR_A_CONV;
      2: rw_addr = `FSR_A_LHI;
      3: rw_addr = `FSR_A_RHI;
      4: rw_addr = `FSR_A_RLO;
      5: rw_addr = `FSR_A_ROFH;
      6: rw_addr = `FSR_A_ROFL;
      7: rw_addr = `FSR_A_RHIL;
      8: rw_addr = `FSR_A_RLOL;
      9: rw_addr = `FSR_A_AMSK;
      10: rw_addr = `FSR_A_CRIT;
      11: rw_addr = `FSR_A_CHYS;
      12: rw_addr = `FSR_A_ENH;
      13: rw_addr = `FSR_A_TLL;
      14: rw_addr = `FSR_A_TLH;
      15: rw_addr = `FSR_A_PCFG;
      16: rw_addr = `FSR_A_SPIN;
      17: rw_addr = `FSR_A_FREQ;
      18: rw_addr = `FSR_A_TOFF;
      19: rw_addr = `FSR_A_THYS;
      default: rw_addr = `FSR_A_FILT;
    endcase
  endfunction : rw_addr

  function automatic fsr_byte_t rw_rst(input int i);
    case (i)
      1: rw_rst = `FSR_V_CONV;
      2: rw_rst = `FSR_V_LHI;
      3: rw_rst = `FSR_V_RHI;
      9: rw_rst = `FSR_V_AMSK;
      10: rw_rst = `FSR_V_CRIT;
      11: rw_rst = `FSR_V_CHYS;
      13, 14: rw_rst = `FSR_V_TLIM;
      15: rw_rst = `FSR_V_PCFG;
      16: rw_rst = `FSR_V_SPIN;
      17: rw_rst = `FSR_V_FREQ;
      19: rw_rst = `FSR_V_THYS;
      default: rw_rst = `FSR_V_ZERO;
    endcase
  endfunction : rw_rst

  function automatic fsr_byte_t rw_mask(input int i);
    case (i)
      6, 7, 8: rw_mask = 8'he0;
      9: rw_mask = 8'h5b;
      12: rw_mask = 8'h7f;
      13: rw_mask = 8'hfc;
      15: rw_mask = 8'h3b;
      16, 18: rw_mask = 8'h3f;
      17, 19: rw_mask = 8'h1f;
      20: rw_mask = 8'h07;
      default: rw_mask = 8'hff;
    endcase
  endfunction : rw_mask

  function automatic fsr_byte_t rw_gate(input int i);
    case (i)
      12: rw_gate = 8'h07;
      16, 17, 18, 19: rw_gate = 8'hff;
      default: rw_gate = 8'h00;
    endcase
  endfunction : rw_gate

  fsr_byte_t canon;
  fsr_byte_t rw_q [NRW];
  fsr_byte_t rd_d;
  fsr_byte_t duty_q;
  fsr_byte_t duty_d;
  fsr_byte_t lut_q [`FSR_LUT_N];
  fsr_idx_t  lut_idx;
  logic      prog_en;
  logic      hifreq;
  logic      hires_d;
  logic      lut_hit;
  logic      duty_we;
  logic      lut_we;

  // Mirror addresses fold onto their primary register before any decode.
  assign canon = (reg_addr == `FSR_A_CFG_M)  ? `FSR_A_CFG  :
                 (reg_addr == `FSR_A_CONV_M) ? `FSR_A_CONV :
                 (reg_addr == `FSR_A_LHI_M)  ? `FSR_A_LHI  :
                 (reg_addr == `FSR_A_RHI_M)  ? `FSR_A_RHI  :
                 (reg_addr == `FSR_A_RLO_M)  ? `FSR_A_RLO  : reg_addr;

  assign prog_en = rw_q[I_PCFG][`FSR_B_PROG];
  // High-frequency setting: frequency code and clock select give the fastest output.
  assign hifreq  = (rw_q[I_FREQ][4:0] == `FSR_HF_PWMF) && (rw_q[I_PCFG][`FSR_B_CKSL] == `FSR_HF_CKSL);
  assign hires_d = hifreq && rw_q[I_ENH][`FSR_B_PHR];
  assign lut_hit = (canon >= `FSR_A_LUT0) && (canon <= `FSR_A_LUTN);
  assign lut_idx = fsr_idx_t'(canon - `FSR_A_LUT0);
  assign duty_we = reg_wr && (canon == `FSR_A_DUTY) && prog_en;
  assign lut_we  = reg_wr && lut_hit && prog_en;
  assign duty_d  = hires_d ? reg_wdata : {2'b00, reg_wdata[5:0]};

  // Gated bits lose their write enable while programming is off; unmatched writes hit nothing.
  for (genvar i = 0; i < NRW; i++) begin : g_rw
    logic      we;
    fsr_byte_t wm;
    assign we = reg_wr && (canon == rw_addr(i));
    assign wm = rw_mask(i) & (prog_en ? 8'hff : ~rw_gate(i));
    fsr_reg_cell #(
      .RST (rw_rst(i))
    ) u_cell (
      .clk   (clk),
      .rst   (rst),
      .we    (we),
      .wmask (wm),
      .wdata (reg_wdata),
      .q     (rw_q[i])
    );
  end

  always_ff @(posedge clk) begin
    if (rst) duty_q <= `FSR_V_ZERO;
    else if (duty_we) duty_q <= duty_d;
  end

  // Table entries alternate temperature and duty; each kind has its own reset value.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < `FSR_LUT_N; k++) begin
        lut_q[k] <= k[0] ? `FSR_V_LUTP : `FSR_V_LUTT;
      end
    end else if (lut_we) begin
      lut_q[lut_idx] <= reg_wdata;
    end
  end

  // Read-back; unused holes and the write-only trigger read zero.
  always_comb begin
    rd_d = `FSR_V_ZERO;
    for (int i = 0; i < NRW; i++) begin
      if (canon == rw_addr(i)) rd_d = rw_q[i];
    end
    if (lut_hit) rd_d = lut_q[lut_idx];
    case (canon)
      `FSR_A_LTEMP: rd_d = local_temp_in;
      `FSR_A_RTSH:  rd_d = remote_signed_hi_in;
      `FSR_A_RTSL:  rd_d = remote_signed_lo_in;
      `FSR_A_RTUH:  rd_d = remote_unsigned_hi_in;
      `FSR_A_RTUL:  rd_d = remote_unsigned_lo_in;
      `FSR_A_ALST:  rd_d = alert_flags_in;
      `FSR_A_POR:   rd_d = {not_ready_flag, 7'h00};
      `FSR_A_TCL:   rd_d = fan_count_lo_in;
      `FSR_A_TCH:   rd_d = fan_count_hi_in;
      `FSR_A_DUTY:  rd_d = prog_en ? duty_q : fan_duty_in;
      `FSR_A_MAKER: rd_d = MAKER_CODE; // Value is arbitrary.
      `FSR_A_REV:   rd_d = REV_CODE; // Value is arbitrary.
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata               <= `FSR_V_ZERO;
      table_rd_data           <= `FSR_V_ZERO;
      single_conversion_pulse <= 1'b0;
      pwm_manual_duty         <= `FSR_V_ZERO;
      high_res_active         <= 1'b0;
      smoothing_active        <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata <= rd_d;
      table_rd_data           <= (table_rd_idx < 5'(`FSR_LUT_N)) ? lut_q[table_rd_idx] : `FSR_V_ZERO;
      single_conversion_pulse <= reg_wr && (canon == `FSR_A_SHOT);
      pwm_manual_duty         <= hires_d ? duty_q : {2'b00, duty_q[5:0]};
      high_res_active         <= hires_d;
      smoothing_active        <= hifreq && rw_q[I_ENH][`FSR_B_PSRR];
    end
  end

  assign fan_program_enable         = rw_q[I_PCFG][`FSR_B_PROG];
  assign pwm_speed_config           = rw_q[I_PCFG];
  assign fan_startup_config         = rw_q[I_SPIN];
  assign pwm_frequency_select       = rw_q[I_FREQ];
  assign enhanced_settings          = rw_q[I_ENH];
  assign table_temp_offset          = rw_q[I_TOFF];
  assign table_hysteresis           = rw_q[I_THYS];
  assign main_configuration         = rw_q[I_CFG];
  assign conversion_rate            = rw_q[I_CONV];
  assign local_high_limit           = rw_q[I_LHI];
  assign remote_high_limit_upper    = rw_q[I_RHI];
  assign remote_low_limit_upper     = rw_q[I_RLO];
  assign remote_critical_limit      = rw_q[I_CRIT];
  assign remote_critical_hysteresis = rw_q[I_CHYS];
  assign alert_masking              = rw_q[I_AMSK];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  alias_write_a : assert property (
    reg_wr && (reg_addr == `FSR_A_CFG_M) |=> main_configuration == $past(reg_wdata))
    else $error("Alias write did not reach the configuration register.");

  alias_read_a : assert property (
    reg_rd && (reg_addr == `FSR_A_RHI_M) |=> reg_rdata == $past(remote_high_limit_upper))
    else $error("Alias read did not return the remote high limit.");

  duty_gate_a : assert property (
    reg_wr && (canon == `FSR_A_DUTY) && !prog_en |=> $stable(duty_q))
    else $error("Duty value changed while programming was off.");

  pwm_cfg_a : assert property (
    reg_wr && (canon == `FSR_A_PCFG) |=> pwm_speed_config == ($past(reg_wdata) & 8'h3b))
    else $error("PWM configuration write stored the wrong bits.");

  freq_write_a : assert property (
    reg_wr && (canon == `FSR_A_FREQ) && prog_en |=> pwm_frequency_select == {3'b000, $past(reg_wdata[4:0])})
    else $error("Frequency write stored the wrong bits.");

  hires_gate_a : assert property (
    high_res_active || smoothing_active |-> $past(hifreq))
    else $error("Enhanced function active away from the high-frequency setting.");

  duty_width_a : assert property (
    duty_we && !hires_d ##1 !hires_d |=> pwm_manual_duty[7:6] == 2'b00 && pwm_manual_duty[5:0] == $past(reg_wdata[5:0], 2))
    else $error("Manual duty not limited to six bits.");

  spin_gate_a : assert property (
    reg_wr && (canon == `FSR_A_SPIN) && !prog_en |=> $stable(fan_startup_config))
    else $error("Spin-up register changed while programming was off.");

  free_write_a : assert property (
    reg_wr && (canon == `FSR_A_CRIT) |=> remote_critical_limit == $past(reg_wdata))
    else $error("Critical limit write was not accepted.");

  reset_vals_a : assert property (@(posedge clk) $fell(rst) |->
    remote_high_limit_upper == `FSR_V_RHI && local_high_limit == `FSR_V_LHI && table_hysteresis == `FSR_V_THYS)
    else $error("Reset defaults of limits or hysteresis are wrong.");

  unused_read_a : assert property (
    reg_rd && (reg_addr == 8'h06 || reg_addr == 8'h0c) |=> reg_rdata == 8'h00)
    else $error("Unused location did not read zero.");

  ro_write_a : assert property (
    reg_wr && (canon == `FSR_A_POR || canon == 8'h06) |=> $stable(pwm_speed_config) && $stable(duty_q))
    else $error("Write to read-only or unused location changed state.");

  duty_read_a : assert property (
    reg_rd && (canon == `FSR_A_DUTY) && !prog_en |=> reg_rdata == $past(fan_duty_in))
    else $error("Duty read did not return the live duty while programming was off.");

  hires_duty_a : assert property (
    duty_we && hires_d |=> duty_q == $past(reg_wdata))
    else $error("Extended duty write did not keep all eight bits.");

  freq_gate_a : assert property (
    reg_wr && (canon == `FSR_A_FREQ) && !prog_en |=> $stable(pwm_frequency_select))
    else $error("Frequency register changed while programming was off.");

  enh_gate_a : assert property (
    reg_wr && (canon == `FSR_A_ENH) && !prog_en |=> enhanced_settings[2:0] == $past(enhanced_settings[2:0]))
    else $error("Smoothing bits changed while programming was off.");

  table_gate_a : assert property (
    reg_wr && lut_hit && !prog_en |=> lut_q[$past(lut_idx)] == $past(lut_q[lut_idx]))
    else $error("Table entry changed while programming was off.");

  table_write_a : assert property (
    lut_we |=> lut_q[$past(lut_idx)] == $past(reg_wdata))
    else $error("Table write was not stored.");

  hyst_write_a : assert property (
    reg_wr && (canon == `FSR_A_THYS) && prog_en |=> table_hysteresis == {3'b000, $past(reg_wdata[4:0])})
    else $error("Hysteresis write stored the wrong bits.");

  lut_write_c : cover property (lut_we ##1 !prog_en);
  hires_c     : cover property (duty_we && hires_d);
  shot_c      : cover property (single_conversion_pulse);
  gate_block_c : cover property (reg_wr && (canon == `FSR_A_SPIN) && !prog_en);
endmodule : fsr_regmap
`default_nettype wire

// ===== fsr_regs.svh
// Register offsets, reset values, field positions, high-frequency codes and table size of the fan sensor register map.
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH
`define FSR_A_LTEMP 8'h00
`define FSR_A_RTSH 8'h01
`define FSR_A_ALST 8'h02
`define FSR_A_CFG 8'h03
`define FSR_A_CONV 8'h04
`define FSR_A_LHI 8'h05
`define FSR_A_RHI 8'h07
`define FSR_A_RLO 8'h08
`define FSR_A_CFG_M 8'h09
`define FSR_A_CONV_M 8'h0a
`define FSR_A_LHI_M 8'h0b
`define FSR_A_RHI_M 8'h0d
`define FSR_A_RLO_M 8'h0e
`define FSR_A_SHOT 8'h0f
`define FSR_A_RTSL 8'h10
`define FSR_A_ROFH 8'h11
`define FSR_A_ROFL 8'h12
`define FSR_A_RHIL 8'h13
`define FSR_A_RLOL 8'h14
`define FSR_A_AMSK 8'h16
`define FSR_A_CRIT 8'h19
`define FSR_A_CHYS 8'h21
`define FSR_A_RTUH 8'h31
`define FSR_A_RTUL 8'h32
`define FSR_A_POR 8'h33
`define FSR_A_ENH 8'h45
`define FSR_A_TCL 8'h46
`define FSR_A_TCH 8'h47
`define FSR_A_TLL 8'h48
`define FSR_A_TLH 8'h49
`define FSR_A_PCFG 8'h4a
`define FSR_A_SPIN 8'h4b
`define FSR_A_DUTY 8'h4c
`define FSR_A_FREQ 8'h4d
`define FSR_A_TOFF 8'h4e
`define FSR_A_THYS 8'h4f
`define FSR_A_LUT0 8'h50
`define FSR_A_LUTN 8'h67
`define FSR_A_FILT 8'hbf
`define FSR_A_MAKER 8'hfe
`define FSR_A_REV 8'hff
`define FSR_V_CONV 8'h08
`define FSR_V_LHI 8'h46
`define FSR_V_RHI 8'h69
`define FSR_V_AMSK 8'ha4
`define FSR_V_CRIT 8'h6e
`define FSR_V_CHYS 8'h0a
`define FSR_V_TLIM 8'hff
`define FSR_V_PCFG 8'h20
`define FSR_V_SPIN 8'h3f
`define FSR_V_FREQ 8'h17
`define FSR_V_THYS 8'h04
`define FSR_V_LUTT 8'h7f
`define FSR_V_LUTP 8'h3f
`define FSR_V_ZERO 8'h00
`define FSR_B_PROG 5
`define FSR_B_POL 4
`define FSR_B_CKSL 3
`define FSR_B_PHR 4
`define FSR_B_LRES 5
`define FSR_B_PSRR 0
`define FSR_B_NR 7
`define FSR_HF_PWMF 5'h08
`define FSR_HF_CKSL 1'b0
`define FSR_LUT_N 24
`endif

// ===== fsr_pkg.sv
// Types shared by the fan sensor register map.
package fsr_pkg;
  typedef logic [7:0] fsr_byte_t;
  typedef logic [4:0] fsr_idx_t;
endpackage : fsr_pkg

// ===== fsr_reg_cell.sv
// One byte-wide register with a per-bit write mask and a fixed reset value.
`timescale 1ns/100ps
`default_nettype none
module fsr_reg_cell
  import fsr_pkg::*;
#(
  parameter fsr_byte_t RST = 8'h00
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      we,
  input  wire fsr_byte_t wmask,
  input  wire fsr_byte_t wdata,
  output var  fsr_byte_t q
);
  fsr_byte_t q_d;
  // Masked bits keep their value, so reserved bits hold their reset level.
  assign q_d = we ? ((q & ~wmask) | (wdata & wmask)) : q;
  always_ff @(posedge clk) begin
    if (rst) q <= RST;
    else q <= q_d;
  end
endmodule : fsr_reg_cell
`default_nettype wire

// ===== fsr_host_model.sv
// Host model that reaches the register bank through its byte write and read strobes.
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model
  import fsr_pkg::*;
(
  input  wire logic      clk,
  output var  logic      reg_wr,
  output var  logic      reg_rd,
  output var  fsr_byte_t reg_addr,
  output var  fsr_byte_t reg_wdata,
  input  wire fsr_byte_t reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse of their last value.
  task automatic wr(input fsr_byte_t a, input fsr_byte_t d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input fsr_byte_t a, output fsr_byte_t d);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd

  // Polls the power-on status until the not-ready flag is clear, giving up after 50 reads.
  task automatic wait_ready(output logic ok);
    fsr_byte_t v;
    ok = 1'b0;
    for (int i = 0; i < 50 && !ok; i++) begin
      rd(8'h33, v);
      ok = (v[7] === 1'b0);
    end
  endtask : wait_ready
endmodule : fsr_host_model
`default_nettype wire

// ===== tb_fan_sensor_register_map.sv
// Self-checking bench for the fan sensor register bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_fan_sensor_register_map
  import fsr_pkg::*;
;
  logic      clk;
  logic      rst;
  logic      not_ready_flag;
  fsr_byte_t fan_duty_in;
  fsr_idx_t  table_rd_idx;
  fsr_byte_t ro_v [8];
  wire logic reg_wr;
  wire logic reg_rd;
  wire fsr_byte_t reg_addr;
  wire fsr_byte_t reg_wdata;
  wire fsr_byte_t reg_rdata;
  wire fsr_byte_t table_rd_data;
  wire fsr_byte_t pwm_speed_config;
  wire fsr_byte_t fan_startup_config;
  wire fsr_byte_t pwm_frequency_select;
  wire fsr_byte_t remote_critical_limit;
  wire fsr_byte_t pwm_manual_duty;
  wire logic single_conversion_pulse;
  wire logic fan_program_enable;
  wire logic high_res_active;
  wire fsr_byte_t enhanced_settings;
  wire fsr_byte_t table_temp_offset;
  wire fsr_byte_t table_hysteresis;
  wire fsr_byte_t main_configuration;
  wire fsr_byte_t conversion_rate;
  wire fsr_byte_t local_high_limit;
  wire fsr_byte_t remote_high_limit_upper;
  wire fsr_byte_t remote_low_limit_upper;
  wire fsr_byte_t remote_critical_hysteresis;
  wire fsr_byte_t alert_masking;
  wire logic smoothing_active;
  int        mismatches = 0;
  int        n_checks = 0;
  int        cnt;
  fsr_byte_t v;
  logic      ok;
  fsr_byte_t ro_a [8] = '{8'h00, 8'h01, 8'h10, 8'h31, 8'h32, 8'h02, 8'h46, 8'h47};
  fsr_byte_t un_a [9] = '{8'h06, 8'h0c, 8'h15, 8'h17, 8'h1a, 8'h22, 8'h34, 8'h68, 8'hc0};
  logic [15:0] al_t [5] = '{16'h0903, 16'h0a04, 16'h0b05, 16'h0d07, 16'h0e08};
  logic [15:0] rst_t [22] = '{16'h0300, 16'h0408, 16'h0546, 16'h0769, 16'h0800, 16'h1100, 16'h1200, 16'h1300,
    16'h1400, 16'h16a4, 16'h196e, 16'h210a, 16'h4500, 16'h48ff, 16'h49ff, 16'h4a20, 16'h4b3f, 16'h4c00,
    16'h4d17, 16'h4e00, 16'h4f04, 16'hbf00};

  // Identity codes are arbitrary.
  fsr_regmap #(.MAKER_CODE(8'h5a), .REV_CODE(8'h3c)) uut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .local_temp_in(ro_v[0]), .remote_signed_hi_in(ro_v[1]),
    .remote_signed_lo_in(ro_v[2]), .remote_unsigned_hi_in(ro_v[3]), .remote_unsigned_lo_in(ro_v[4]),
    .alert_flags_in(ro_v[5]), .not_ready_flag(not_ready_flag), .fan_count_lo_in(ro_v[6]),
    .fan_count_hi_in(ro_v[7]), .fan_duty_in(fan_duty_in), .table_rd_idx(table_rd_idx),
    .table_rd_data(table_rd_data), .single_conversion_pulse(single_conversion_pulse),
    .fan_program_enable(fan_program_enable), .pwm_speed_config(pwm_speed_config),
    .fan_startup_config(fan_startup_config), .pwm_frequency_select(pwm_frequency_select),
    .enhanced_settings(enhanced_settings), .table_temp_offset(table_temp_offset),
    .table_hysteresis(table_hysteresis), .main_configuration(main_configuration),
    .conversion_rate(conversion_rate), .local_high_limit(local_high_limit),
    .remote_high_limit_upper(remote_high_limit_upper), .remote_low_limit_upper(remote_low_limit_upper),
    .remote_critical_limit(remote_critical_limit), .remote_critical_hysteresis(remote_critical_hysteresis),
    .alert_masking(alert_masking),
    .pwm_manual_duty(pwm_manual_duty), .high_res_active(high_res_active), .smoothing_active(smoothing_active));

  fsr_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask : done

  task automatic fan_setup();
    host.wr(8'h4a, 8'h33);
    host.wr(8'h4b, 8'h2a);
    host.wr(8'h4d, 8'h08);
  endtask : fan_setup

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst = 1'b1;
    not_ready_flag = 1'b1;
    fan_duty_in = 8'h77;
    table_rd_idx = 5'd0;
    foreach (ro_v[i]) ro_v[i] = 8'h00;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    host.rd(8'h33, v);
    `CHK("not ready", 8'h80, v)
    fork
      begin idle(20); not_ready_flag = 1'b0; end
      host.wait_ready(ok);
    join
    `CHK("ready poll", 1'b1, ok)
    done("ready");
    if (ok !== 1'b1) wrap_up();
    for (int i = 0; i < 22; i++) begin
      host.rd(rst_t[i][15:8], v);
      `CHK("reset value", rst_t[i][7:0], v)
    end
    `CHK("local limit out", 8'h46, local_high_limit)
    `CHK("remote limit out", 8'h69, remote_high_limit_upper)
    `CHK("hysteresis out", 8'h04, table_hysteresis)
    done("defaults");
    for (int i = 0; i < 5; i++) begin
      host.wr(al_t[i][15:8], 8'h30 ^ al_t[i][7:0]);
      host.rd(al_t[i][7:0], v);
      `CHK("alias write", 8'h30 ^ al_t[i][7:0], v)
      host.wr(al_t[i][7:0], 8'hc0 ^ al_t[i][7:0]);
      host.rd(al_t[i][15:8], v);
      `CHK("alias read", 8'hc0 ^ al_t[i][7:0], v)
    end
    `CHK("config out", 8'hc3, main_configuration)
    `CHK("rate out", 8'hc4, conversion_rate)
    `CHK("local limit alias", 8'hc5, local_high_limit)
    `CHK("remote limit alias", 8'hc7, remote_high_limit_upper)
    `CHK("low limit alias", 8'hc8, remote_low_limit_upper)
    done("aliases");
    fan_setup();
    host.wr(8'h45, 8'h11);
    host.wr(8'h4f, 8'hf3);
    idle(2);
    `CHK("pwm config", 8'h33, pwm_speed_config)
    `CHK("spin-up", 8'h2a, fan_startup_config)
    `CHK("frequency", 8'h08, pwm_frequency_select)
    `CHK("hysteresis write", 8'h13, table_hysteresis)
    `CHK("high res", 1'b1, high_res_active)
    `CHK("smoothing", 1'b1, smoothing_active)
    host.wr(8'h4c, 8'hc5);
    idle(3);
    `CHK("duty 8 bit", 8'hc5, pwm_manual_duty)
    host.rd(8'h4c, v);
    `CHK("duty read", 8'hc5, v)
    host.wr(8'h4d, 8'h09);
    idle(2);
    `CHK("high res off", 1'b0, high_res_active)
    `CHK("smoothing off", 1'b0, smoothing_active)
    host.wr(8'h4c, 8'hc5);
    idle(3);
    `CHK("duty 6 bit", 8'h05, pwm_manual_duty)
    host.wr(8'h4d, 8'h08);
    host.wr(8'h4a, 8'h3b);
    idle(2);
    `CHK("slow clock", 1'b0, high_res_active)
    done("manual duty");
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    host.rd(8'h4a, v);
    `CHK("second reset", 8'h20, v)
    `CHK("duty cleared", 8'h00, pwm_manual_duty)
    `CHK("local limit reset", 8'h46, local_high_limit)
    `CHK("remote limit reset", 8'h69, remote_high_limit_upper)
    `CHK("hysteresis reset", 8'h04, table_hysteresis)
    fan_setup();
    host.wr(8'h50, 8'h30);
    host.wr(8'h4e, 8'h10);
    idle(2);
    `CHK("table entry", 8'h30, table_rd_data)
    `CHK("table offset", 8'h10, table_temp_offset)
    table_rd_idx = 5'd1;
    idle(2);
    `CHK("table default", 8'h3f, table_rd_data)
    table_rd_idx = 5'd24;
    idle(2);
    `CHK("table range", 8'h00, table_rd_data)
    table_rd_idx = 5'd0;
    host.wr(8'h4a, 8'h13);
    idle(2);
    `CHK("program off", 1'b0, fan_program_enable)
    host.wr(8'h4b, 8'h11);
    host.wr(8'h50, 8'h44);
    host.wr(8'h4c, 8'h22);
    host.wr(8'h45, 8'h17);
    host.wr(8'h4d, 8'h1f);
    host.rd(8'h4b, v);
    `CHK("gated spin-up", 8'h2a, v)
    `CHK("gated table", 8'h30, table_rd_data)
    host.rd(8'h4c, v);
    `CHK("live duty", 8'h77, v)
    host.rd(8'h45, v);
    `CHK("gated enhanced", 8'h10, v)
    `CHK("enhanced out", 8'h10, enhanced_settings)
    host.rd(8'h4d, v);
    `CHK("gated frequency", 8'h08, v)
    done("gating");
    host.wr(8'h19, 8'h55);
    host.wr(8'h16, 8'h12);
    host.wr(8'h21, 8'h33);
    idle(2);
    `CHK("free write", 8'h55, remote_critical_limit)
    `CHK("alert mask", 8'hb6, alert_masking)
    `CHK("critical hysteresis", 8'h33, remote_critical_hysteresis)
    cnt = 0;
    fork
      host.wr(8'h0f, 8'h01);
      repeat (4) begin @(negedge clk); if (single_conversion_pulse === 1'b1) cnt++; end
    join
    `CHK("one-shot", 1, cnt)
    done("free writes");
    host.wr(8'h03, 8'hc3);
    foreach (ro_v[i]) ro_v[i] = ro_a[i] ^ 8'ha5;
    foreach (un_a[i]) host.wr(un_a[i], 8'hff);
    foreach (ro_a[i]) host.wr(ro_a[i], 8'h00);
    host.wr(8'hfe, 8'h00);
    host.wr(8'h33, 8'hff);
    foreach (un_a[i]) begin
      host.rd(un_a[i], v);
      `CHK("unused", 8'h00, v)
    end
    foreach (ro_a[i]) begin
      host.rd(ro_a[i], v);
      `CHK("read-only", ro_a[i] ^ 8'ha5, v)
    end
    host.rd(8'hfe, v);
    `CHK("maker", 8'h5a, v)
    host.rd(8'hff, v);
    `CHK("revision", 8'h3c, v)
    host.rd(8'h33, v);
    `CHK("status kept", 8'h00, v)
    host.rd(8'h03, v);
    `CHK("state kept", 8'hc3, v)
    done("unused and read-only");
    wrap_up();
  end
endmodule : tb_fan_sensor_register_map
`default_nettype wire
